// ===== hdl/rvt_pkg.sv
// Package of constants and types for the voting trip logic.
`default_nettype none
package rvt_pkg;
    // Channel and group counts.
    localparam int NUM_CHAN     = 12;
    localparam int NUM_VOTE     = 2;
    localparam int NUM_GRP      = 3;
    localparam int TEMP_W       = 12;
    localparam int CHAN_IDX_W   = 4;
    localparam int ADDR_W       = 8;
    // Channel index ranges of each logical group.
    localparam int WIND_FIRST   = 0;
    localparam int WIND_LAST    = 5;
    localparam int AMB_FIRST    = 6;
    localparam int AMB_LAST     = 7;
    localparam int AUX_FIRST    = 8;
    localparam int AUX_LAST     = 11;
    // Register byte offsets.
    localparam logic [ADDR_W-1:0] OFS_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CHAN_EN   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_VOTE0     = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_VOTE1     = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_GRP_THR   = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_LIVE      = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CLR   = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_IRQ_EN    = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_CHAN_THR  = 8'h40;
    localparam logic [ADDR_W-1:0] OFS_CHAN_TEMP = 8'h80;
    // Control register fields.
    localparam int CTRL_FUNC_BIT  = 0;
    localparam int CTRL_SRC_BIT   = 1;
    localparam int CTRL_BLOCK_BIT = 2;
    // Vote register fields.
    localparam int VOTE_CNT_LSB   = 16;
    localparam int VOTE_CNT_W     = 4;
    // Live status fields.
    localparam int LIVE_GRP_LSB   = 12;
    localparam int LIVE_VOTE_LSB  = 16;
    localparam int LIVE_TRIP_BIT  = 20;
    localparam int LIVE_ALARM_BIT = 21;
    // Interrupt event bits.
    localparam int IRQ_W          = 3;
    localparam int IRQ_TRIP_BIT   = 0;
    localparam int IRQ_ALARM_BIT  = 1;
    localparam int IRQ_VOTE_BIT   = 2;
    // Reset values.
    localparam logic [31:0]       RST_CTRL   = 32'h0000_0000;
    localparam logic [11:0]       RST_CHAN_EN = 12'h000;
    localparam logic [TEMP_W-1:0] RST_THR    = 12'hfff;
    localparam logic [TEMP_W-1:0] RST_TEMP   = 12'h000;
    // Source selector encoding.
    typedef enum logic [0:0] {
        RVT_SRC_DEFAULT = 1'b0,
        RVT_SRC_VOTING  = 1'b1
    } rvt_src_e;
    typedef logic [TEMP_W-1:0] rvt_temp_t;
endpackage : rvt_pkg
`default_nettype wire

// ===== hdl/rvt_trip_logic.sv
// Temperature trip, voting and collective alarm logic with an APB register file.
//
// The APB slave port and the address map are this design's own decisions.
`default_nettype none
// Summary of operation
// - Each voting group has member mask, vote count.
// - All twelve channel trips selectable in any group.
// - Collective timeout alarm ORs all timeout alarms.
// - Selector routes default OR or voting OR.
// - Block command suppresses channel, group, voting trips.
// - Multiplexed temperature words demultiplexed per channel.
// - Inputs 1-6 winding, 7-8 ambient, 9-12 auxiliary.
// - Vote counts selected, enabled, active tripped channels.
// - Group decision uses hottest member temperature.
module rvt_trip_logic
    import rvt_pkg::*;
(
    // Clock and reset.
    input  wire logic                  ref_clk,
    input  wire logic                  reset_n,
    // APB slave.
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Multiplexed temperature words from the remote module.
    input  wire logic                  mux_valid,
    input  wire logic [CHAN_IDX_W-1:0] mux_channel,
    input  wire logic [TEMP_W-1:0]     mux_temp,
    // Timeout alarms from sensor and group supervision.
    input  wire logic [NUM_CHAN-1:0]   sensor_timeout_alarm,
    input  wire logic                  winding_group_timeout_alarm,
    input  wire logic                  ambient_group_timeout_alarm,
    input  wire logic                  auxiliary_group_timeout_alarm,
    // Collective outputs.
    output logic                       temp_trip,
    output logic                       timeout_alarm,
    output logic [NUM_VOTE-1:0]        voting_trip,
    output logic                       irq
);

    // Counts set bits of a channel vector.
    function automatic logic [CHAN_IDX_W-1:0] count_ones(input logic [NUM_CHAN-1:0] v);
        logic [CHAN_IDX_W-1:0] n;
        n = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            n = n + {{(CHAN_IDX_W-1){1'b0}}, v[i]};
        end
        return n;
    endfunction : count_ones

    // Returns the hottest temperature over an inclusive index range.
    function automatic rvt_temp_t hottest(input rvt_temp_t t [NUM_CHAN], input int lo,
                                          input int hi);
        rvt_temp_t m;
        m = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            if (i >= lo && i <= hi && t[i] > m) begin
                m = t[i];
            end
        end
        return m;
    endfunction : hottest

    // Register state.
    logic [31:0]           ctrl;
    logic [NUM_CHAN-1:0]   chan_en;
    logic [NUM_CHAN-1:0]   vote_mask  [NUM_VOTE];
    logic [VOTE_CNT_W-1:0] vote_count [NUM_VOTE];
    rvt_temp_t             grp_thr    [NUM_GRP];
    rvt_temp_t             chan_thr   [NUM_CHAN];
    rvt_temp_t             chan_temp  [NUM_CHAN];
    logic [IRQ_W-1:0]      irq_stat;
    logic [IRQ_W-1:0]      irq_en;
    logic [NUM_CHAN-1:0]   chan_trip;
    logic [NUM_GRP-1:0]    grp_trip;

    // Next values.
    logic [31:0]           next_ctrl;
    logic [NUM_CHAN-1:0]   next_chan_en;
    logic [NUM_CHAN-1:0]   next_vote_mask  [NUM_VOTE];
    logic [VOTE_CNT_W-1:0] next_vote_count [NUM_VOTE];
    rvt_temp_t             next_grp_thr    [NUM_GRP];
    rvt_temp_t             next_chan_thr   [NUM_CHAN];
    rvt_temp_t             next_chan_temp  [NUM_CHAN];
    logic [IRQ_W-1:0]      next_irq_stat;
    logic [IRQ_W-1:0]      next_irq_en;
    logic [NUM_CHAN-1:0]   next_chan_trip;
    logic [NUM_GRP-1:0]    next_grp_trip;
    logic [NUM_VOTE-1:0]   next_voting_trip;
    logic                  next_temp_trip;
    logic                  next_timeout_alarm;
    logic                  next_irq;
    logic [31:0]           next_prdata;
    logic                  next_pready;
    logic                  next_pslverr;

    // Combinational helpers.
    logic                  func_on;
    logic                  blocked;
    logic                  wr_en;
    logic                  acc_en;
    logic [NUM_CHAN-1:0]   raw_trip;
    logic [IRQ_W-1:0]      events;
    rvt_temp_t             grp_hot [NUM_GRP];
    logic [31:0]           rd_val;
    logic                  rd_ok;

    // Evaluation of channel, group, voting and collective signals.
    always_comb begin
        func_on = ctrl[CTRL_FUNC_BIT];
        blocked = ctrl[CTRL_BLOCK_BIT];
        for (int i = 0; i < NUM_CHAN; i++) begin
            raw_trip[i] = func_on && chan_en[i] && (chan_temp[i] >= chan_thr[i]);
            next_chan_trip[i] = raw_trip[i] && !blocked;
        end
        grp_hot[0] = hottest(chan_temp, WIND_FIRST, WIND_LAST);
        grp_hot[1] = hottest(chan_temp, AMB_FIRST, AMB_LAST);
        grp_hot[2] = hottest(chan_temp, AUX_FIRST, AUX_LAST);
        for (int g = 0; g < NUM_GRP; g++) begin
            next_grp_trip[g] = func_on && (grp_hot[g] >= grp_thr[g]) && !blocked;
        end
        for (int v = 0; v < NUM_VOTE; v++) begin
            // Level result, so it falls as soon as the count drops below the setting.
            next_voting_trip[v] = (vote_count[v] != '0) && !blocked
                && (count_ones(raw_trip & vote_mask[v]) >= vote_count[v]);
        end
        if (rvt_src_e'(ctrl[CTRL_SRC_BIT]) == RVT_SRC_VOTING) begin
            next_temp_trip = |next_voting_trip;
        end else begin
            next_temp_trip = (|next_chan_trip) || (|next_grp_trip);
        end
        next_timeout_alarm = (|sensor_timeout_alarm) || winding_group_timeout_alarm
            || ambient_group_timeout_alarm || auxiliary_group_timeout_alarm;
        events = '0;
        events[IRQ_TRIP_BIT]  = next_temp_trip && !temp_trip;
        events[IRQ_ALARM_BIT] = next_timeout_alarm && !timeout_alarm;
        events[IRQ_VOTE_BIT]  = |(next_voting_trip & ~voting_trip);
    end

    // Demultiplexing of temperature words into per-channel values.
    always_comb begin
        for (int i = 0; i < NUM_CHAN; i++) begin
            next_chan_temp[i] = chan_temp[i];
        end
        if (mux_valid && (int'(mux_channel) < NUM_CHAN)) begin
            next_chan_temp[mux_channel] = mux_temp;
        end
    end

    // Read decode.
    always_comb begin
        rd_val = '0;
        rd_ok  = 1'b1;
        if (paddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else if (paddr >= OFS_CHAN_TEMP
                     && paddr < OFS_CHAN_TEMP + ADDR_W'(4 * NUM_CHAN)) begin
            rd_val[TEMP_W-1:0] = chan_temp[paddr[5:2]];
        end else if (paddr >= OFS_CHAN_THR
                     && paddr < OFS_CHAN_THR + ADDR_W'(4 * NUM_CHAN)) begin
            rd_val[TEMP_W-1:0] = chan_thr[paddr[5:2]];
        end else if (paddr >= OFS_GRP_THR
                     && paddr < OFS_GRP_THR + ADDR_W'(4 * NUM_GRP)) begin
            rd_val[TEMP_W-1:0] = grp_thr[paddr[3:2]];
        end else begin
            case (paddr)
                OFS_CTRL:     rd_val[CTRL_BLOCK_BIT:0] = ctrl[CTRL_BLOCK_BIT:0];
                OFS_CHAN_EN:  rd_val[NUM_CHAN-1:0] = chan_en;
                OFS_VOTE0: begin
                    rd_val[NUM_CHAN-1:0] = vote_mask[0];
                    rd_val[VOTE_CNT_LSB +: VOTE_CNT_W] = vote_count[0];
                end
                OFS_VOTE1: begin
                    rd_val[NUM_CHAN-1:0] = vote_mask[1];
                    rd_val[VOTE_CNT_LSB +: VOTE_CNT_W] = vote_count[1];
                end
                OFS_LIVE: begin
                    rd_val[NUM_CHAN-1:0] = chan_trip;
                    rd_val[LIVE_GRP_LSB +: NUM_GRP] = grp_trip;
                    rd_val[LIVE_VOTE_LSB +: NUM_VOTE] = voting_trip;
                    rd_val[LIVE_TRIP_BIT] = temp_trip;
                    rd_val[LIVE_ALARM_BIT] = timeout_alarm;
                end
                OFS_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat;
                OFS_IRQ_CLR:  rd_val = '0;
                OFS_IRQ_EN:   rd_val[IRQ_W-1:0] = irq_en;
                default:      rd_ok = 1'b0;
            endcase
        end
    end

    // Bus handshake and register writes; one wait state per transfer.
    always_comb begin
        acc_en       = psel && penable;
        wr_en        = acc_en && pready && pwrite && rd_ok;
        next_pready  = acc_en && !pready;
        next_pslverr = acc_en && !pready && !rd_ok;
        next_prdata  = (acc_en && !pready && !pwrite) ? rd_val : prdata;
        next_ctrl    = ctrl;
        next_chan_en = chan_en;
        next_irq_en  = irq_en;
        for (int v = 0; v < NUM_VOTE; v++) begin
            next_vote_mask[v]  = vote_mask[v];
            next_vote_count[v] = vote_count[v];
        end
        for (int g = 0; g < NUM_GRP; g++) begin
            next_grp_thr[g] = grp_thr[g];
        end
        for (int i = 0; i < NUM_CHAN; i++) begin
            next_chan_thr[i] = chan_thr[i];
        end
        // Events set sticky bits; a set in the clearing cycle wins.
        next_irq_stat = irq_stat;
        if (wr_en && paddr == OFS_IRQ_CLR) begin
            next_irq_stat = irq_stat & ~pwdata[IRQ_W-1:0];
        end
        next_irq_stat = next_irq_stat | events;
        if (wr_en) begin
            if (paddr >= OFS_CHAN_THR && paddr < OFS_CHAN_THR + ADDR_W'(4 * NUM_CHAN)) begin
                next_chan_thr[paddr[5:2]] = pwdata[TEMP_W-1:0];
            end else if (paddr >= OFS_GRP_THR
                         && paddr < OFS_GRP_THR + ADDR_W'(4 * NUM_GRP)) begin
                next_grp_thr[paddr[3:2]] = pwdata[TEMP_W-1:0];
            end else begin
                case (paddr)
                    OFS_CTRL:    next_ctrl = {29'h0, pwdata[CTRL_BLOCK_BIT:0]};
                    OFS_CHAN_EN: next_chan_en = pwdata[NUM_CHAN-1:0];
                    OFS_VOTE0: begin
                        next_vote_mask[0]  = pwdata[NUM_CHAN-1:0];
                        next_vote_count[0] = pwdata[VOTE_CNT_LSB +: VOTE_CNT_W];
                    end
                    OFS_VOTE1: begin
                        next_vote_mask[1]  = pwdata[NUM_CHAN-1:0];
                        next_vote_count[1] = pwdata[VOTE_CNT_LSB +: VOTE_CNT_W];
                    end
                    OFS_IRQ_EN:  next_irq_en = pwdata[IRQ_W-1:0];
                    default:     next_ctrl = ctrl;
                endcase
            end
        end
        next_irq = |(next_irq_stat & next_irq_en);
    end

    // State registers.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl          <= RST_CTRL;
            chan_en       <= RST_CHAN_EN;
            irq_stat      <= '0;
            irq_en        <= '0;
            chan_trip     <= '0;
            grp_trip      <= '0;
            voting_trip   <= '0;
            temp_trip     <= 1'b0;
            timeout_alarm <= 1'b0;
            irq           <= 1'b0;
            prdata        <= '0;
            pready        <= 1'b0;
            pslverr       <= 1'b0;
            for (int v = 0; v < NUM_VOTE; v++) begin
                vote_mask[v]  <= '0;
                vote_count[v] <= '0;
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_thr[g] <= RST_THR;
            end
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_thr[i]  <= RST_THR;
                chan_temp[i] <= RST_TEMP;
            end
        end else begin
            ctrl          <= next_ctrl;
            chan_en       <= next_chan_en;
            irq_stat      <= next_irq_stat;
            irq_en        <= next_irq_en;
            chan_trip     <= next_chan_trip;
            grp_trip      <= next_grp_trip;
            voting_trip   <= next_voting_trip;
            temp_trip     <= next_temp_trip;
            timeout_alarm <= next_timeout_alarm;
            irq           <= next_irq;
            prdata        <= next_prdata;
            pready        <= next_pready;
            pslverr       <= next_pslverr;
            for (int v = 0; v < NUM_VOTE; v++) begin
                vote_mask[v]  <= next_vote_mask[v];
                vote_count[v] <= next_vote_count[v];
            end
            for (int g = 0; g < NUM_GRP; g++) begin
                grp_thr[g] <= next_grp_thr[g];
            end
            for (int i = 0; i < NUM_CHAN; i++) begin
                chan_thr[i]  <= next_chan_thr[i];
                chan_temp[i] <= next_chan_temp[i];
            end
        end
    end

endmodule : rvt_trip_logic
`default_nettype wire

// ===== tb/rvt_trip_logic_monitor.sv
// Port-level assertions for the voting trip logic.
`default_nettype none
module rvt_trip_logic_monitor
    import rvt_pkg::*;
(
    // Clock and reset.
    input wire logic                  ref_clk,
    input wire logic                  reset_n,
    // APB slave.
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_W-1:0]     paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    input wire logic                  pslverr,
    // Multiplexed temperature words and timeout alarms.
    input wire logic                  mux_valid,
    input wire logic [CHAN_IDX_W-1:0] mux_channel,
    input wire logic [TEMP_W-1:0]     mux_temp,
    input wire logic [NUM_CHAN-1:0]   sensor_timeout_alarm,
    input wire logic                  winding_group_timeout_alarm,
    input wire logic                  ambient_group_timeout_alarm,
    input wire logic                  auxiliary_group_timeout_alarm,
    // Collective outputs.
    input wire logic                  temp_trip,
    input wire logic                  timeout_alarm,
    input wire logic [NUM_VOTE-1:0]   voting_trip,
    input wire logic                  irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       any_timeout;
    logic [2:0] since_cause;
    logic [2:0] next_since_cause;
    // Any of the fifteen timeout inputs.
    assign any_timeout = (|sensor_timeout_alarm) || winding_group_timeout_alarm
        || ambient_group_timeout_alarm || auxiliary_group_timeout_alarm;
    // Cycles since a word or register write could move a trip.
    always_comb begin
        next_since_cause = (mux_valid || (pready && pwrite)) ? 3'h0 :
            (since_cause == 3'h7) ? since_cause : since_cause + 3'h1;
    end
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) since_cause <= 3'h7;
        else since_cause <= next_since_cause;
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_ready_single_cycle: assert property (pready |=> !pready)
        else $error("pready held");
    a_ready_after_access: assert property (psel && $rose(penable) |=> pready)
        else $error("pready late");
    a_ready_needs_access: assert property (pready |-> $past(psel && penable))
        else $error("pready unasked");
    a_error_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr alone");
    a_error_data_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read data");
    a_alarm_set: assert property (any_timeout |=> timeout_alarm)
        else $error("alarm missing");
    a_alarm_clear: assert property (!any_timeout |=> !timeout_alarm)
        else $error("alarm unasked");
    a_trip_has_cause: assert property (
        $changed(voting_trip) || $changed(temp_trip) |-> since_cause < 3'h4)
        else $error("trip moved uncaused");
endmodule : rvt_trip_logic_monitor
bind rvt_trip_logic rvt_trip_logic_monitor u_rvt_trip_logic_monitor (.ref_clk, .reset_n,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mux_valid,
    .mux_channel, .mux_temp, .sensor_timeout_alarm, .winding_group_timeout_alarm,
    .ambient_group_timeout_alarm, .auxiliary_group_timeout_alarm, .temp_trip,
    .timeout_alarm, .voting_trip, .irq);
`default_nettype wire

// ===== tb/rvt_remote_model.sv
// Model of the remote acquisition module on the link.
`default_nettype none
module rvt_remote_model
    import rvt_pkg::*;
(
    // Bench control.
    input  wire logic                       ref_clk,
    input  wire logic                       start,
    input  wire logic                       slow,
    input  wire logic                       bad,
    input  wire logic [NUM_CHAN*TEMP_W-1:0] frame,
    output logic                            busy,
    // Multiplexed words toward the relay.
    output logic                            mux_valid,
    output logic [CHAN_IDX_W-1:0]           mux_channel,
    output logic [TEMP_W-1:0]               mux_temp
);
    timeunit 1ns;
    timeprecision 1ps;
    // Sends every channel in turn; idle lines carry inverted garbage.
    initial begin
        busy = 1'b0;
        mux_valid = 1'b0;
        mux_channel = '0;
        mux_temp = '0;
        forever begin
            @(posedge ref_clk);
            if (start) begin
                busy <= 1'b1;
                for (int i = 0; i <= NUM_CHAN; i++) begin
                    if (i < NUM_CHAN || bad) begin
                        mux_valid <= 1'b1;
                        mux_channel <= (i < NUM_CHAN) ? 4'(i) : 4'hf;
                        mux_temp <= (i < NUM_CHAN) ? frame[i*TEMP_W +: TEMP_W] : 12'hfff;
                        @(posedge ref_clk);
                        if (slow) begin
                            mux_valid <= 1'b0;
                            mux_channel <= ~mux_channel;
                            mux_temp <= ~mux_temp;
                            @(posedge ref_clk);
                        end
                    end
                end
                mux_valid <= 1'b0;
                mux_channel <= ~mux_channel;
                mux_temp <= ~mux_temp;
                busy <= 1'b0;
            end
        end
    end
endmodule : rvt_remote_model
`default_nettype wire

// ===== tb/rvt_trip_logic_bench.sv
// Self-checking bench for the voting trip logic.
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module rvt_trip_logic_bench
    import rvt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [TEMP_W-1:0] CTHR = 12'h100;
    // Design, link and bench state.
    logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq;
    logic mux_valid, start, slow, bad, busy, temp_trip, timeout_alarm, to_any;
    logic winding_group_timeout_alarm, ambient_group_timeout_alarm;
    logic auxiliary_group_timeout_alarm;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, live;
    logic [CHAN_IDX_W-1:0] mux_channel;
    logic [TEMP_W-1:0] mux_temp;
    logic [NUM_CHAN*TEMP_W-1:0] frame;
    logic [NUM_CHAN-1:0] sensor_timeout_alarm;
    logic [NUM_VOTE-1:0] voting_trip;
    logic [14:0] tmo;
    rvt_temp_t temps [NUM_CHAN];
    rvt_temp_t gthr [NUM_GRP];
    logic [11:0] vmask [NUM_VOTE];
    logic [3:0] vcnt [NUM_VOTE];
    logic [33:0] notes [$];
    logic [33:0] note;
    int err_count, comparisons;
    integer seed;
    assign {auxiliary_group_timeout_alarm, ambient_group_timeout_alarm,
            winding_group_timeout_alarm, sensor_timeout_alarm} = tmo;
    rvt_trip_logic u_rvt_trip_logic (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mux_valid, .mux_channel, .mux_temp,
        .sensor_timeout_alarm, .winding_group_timeout_alarm, .ambient_group_timeout_alarm,
        .auxiliary_group_timeout_alarm, .temp_trip, .timeout_alarm, .voting_trip, .irq);
    rvt_remote_model u_rvt_remote_model (.ref_clk, .start, .slow, .bad, .frame, .busy,
        .mux_valid, .mux_channel, .mux_temp);
    // Expected live status word.
    function automatic logic [31:0] exp_live(input logic blk, input logic src);
        logic [11:0] ct;
        logic [2:0] gt;
        logic [1:0] vt;
        int g;
        gt = '0;
        for (int i = 0; i < NUM_CHAN; i++) begin
            ct[i] = temps[i] >= CTHR;
            g = (i <= WIND_LAST) ? 0 : (i <= AMB_LAST) ? 1 : 2;
            if (temps[i] >= gthr[g]) gt[g] = 1'b1;
        end
        for (int v = 0; v < NUM_VOTE; v++)
            vt[v] = vcnt[v] != 4'h0 && $countones(ct & vmask[v]) >= vcnt[v];
        if (blk) {ct, gt, vt} = '0;
        exp_live = {10'h0, to_any, src ? |vt : (|ct || |gt), 2'b0, vt, 1'b0, gt, ct};
    endfunction : exp_live
    // One APB transfer; its expected answer is queued.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic e);
        notes.push_back({!w, e, e ? 32'h0 : d});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'($random(seed));
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (!pready) @(posedge ref_clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    task automatic set_votes();
        for (int v = 0; v < NUM_VOTE; v++)
            apb(1'b1, OFS_VOTE0 + 8'(4 * v), {12'h0, vcnt[v], 4'h0, vmask[v]}, 1'b0);
    endtask : set_votes
    task automatic send(input logic s);
        for (int i = 0; i < NUM_CHAN; i++) frame[i*TEMP_W +: TEMP_W] <= temps[i];
        slow <= s;
        bad <= s;
        start <= 1'b1;
        @(posedge ref_clk);
        start <= 1'b0;
        @(posedge ref_clk);
        while (busy) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
    endtask : send
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test
    // Clock.
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Watcher checks the oldest note per transfer.
    always @(posedge ref_clk) begin
        if (psel && penable && pready) begin
            if (notes.size() == 0) note = 34'h3_0000_0000;
            else note = notes.pop_front();
            `CHK(pslverr, note[32])
            if (note[33]) `CHK(prdata, note[31:0])
        end
    end
    // Watchdog.
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        seed = 32'h75ad;
        {psel, penable, pwrite, paddr, pwdata, start, slow, bad, frame, tmo} = '0;
        to_any = 1'b0;
        reset_n = 1'b0;
        foreach (gthr[g]) gthr[g] = 12'hfff;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(posedge ref_clk);
        apb(1'b0, OFS_CTRL, 32'h0, 1'b0);
        apb(1'b0, OFS_CHAN_THR + 8'h2c, 32'hfff, 1'b0);
        apb(1'b0, 8'h30, 32'h0, 1'b1);
        apb(1'b1, 8'h02, 32'h1, 1'b1);
        apb(1'b0, OFS_IRQ_CLR, 32'h0, 1'b0);
        $display("Test refusals done");
        apb(1'b1, OFS_CTRL, 32'h1, 1'b0);
        apb(1'b1, OFS_CHAN_EN, 32'hfff, 1'b0);
        apb(1'b1, OFS_IRQ_EN, 32'h7, 1'b0);
        for (int i = 0; i < NUM_CHAN; i++) begin
            apb(1'b1, OFS_CHAN_THR + 8'(4 * i), {20'h0, CTHR}, 1'b0);
            temps[i] = 12'($random(seed)) & 12'h1ff;
        end
        temps[0] = 12'h1ff;
        live = exp_live(1'b0, 1'b0);
        vmask[0] = 12'($random(seed));
        vmask[1] = 12'hfff;
        vcnt[0] = 4'($countones(live[11:0] & vmask[0]));
        vcnt[1] = 4'($countones(live[11:0]) + 1);
        set_votes();
        send(1'b1);
        for (int i = 0; i < NUM_CHAN; i++)
            apb(1'b0, OFS_CHAN_TEMP + 8'(4 * i), {20'h0, temps[i]}, 1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b0), 1'b0);
        apb(1'b1, OFS_CTRL, 32'h3, 1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b1), 1'b0);
        apb(1'b1, OFS_CTRL, 32'h7, 1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b1, 1'b1), 1'b0);
        apb(1'b1, OFS_CTRL, 32'h5, 1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b1, 1'b0), 1'b0);
        apb(1'b1, OFS_CTRL, 32'h3, 1'b0);
        $display("Test demux, source and block done");
        foreach (temps[i]) temps[i] = 12'h1ff;
        vmask[0] = 12'hfff;
        vcnt[0] = 4'hc;
        set_votes();
        send(1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b1), 1'b0);
        temps[11] = 12'h0ff;
        send(1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b1), 1'b0);
        $display("Test vote count done");
        foreach (temps[i]) temps[i] = 12'($random(seed)) & 12'h17f;
        temps[WIND_FIRST + 2] = 12'h1a0;
        gthr = '{12'h180, 12'h1ff, 12'h050};
        for (int g = 0; g < NUM_GRP; g++)
            apb(1'b1, OFS_GRP_THR + 8'(4 * g), {20'h0, gthr[g]}, 1'b0);
        apb(1'b1, OFS_CTRL, 32'h1, 1'b0);
        send(1'b1);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b0), 1'b0);
        $display("Test group hottest done");
        apb(1'b1, OFS_IRQ_CLR, 32'h7, 1'b0);
        apb(1'b0, OFS_IRQ_STAT, 32'h0, 1'b0);
        apb(1'b1, OFS_IRQ_EN, 32'h0, 1'b0);
        for (int k = 0; k < 15; k++) begin
            tmo <= 15'h1 << k;
            to_any = 1'b1;
            repeat (2) @(posedge ref_clk);
            apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b0), 1'b0);
            tmo <= '0;
            to_any = 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b0), 1'b0);
        apb(1'b0, OFS_IRQ_STAT, 32'h2, 1'b0);
        `CHK(irq, 1'b0)
        apb(1'b1, OFS_IRQ_EN, 32'h7, 1'b0);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b1)
        apb(1'b1, OFS_IRQ_CLR, 32'h2, 1'b0);
        repeat (2) @(posedge ref_clk);
        `CHK(irq, 1'b0)
        apb(1'b1, OFS_LIVE, 32'hffff_ffff, 1'b0);
        apb(1'b0, OFS_LIVE, exp_live(1'b0, 1'b0), 1'b0);
        $display("Test alarm and irq done");
        end_of_test();
    end
endmodule : rvt_trip_logic_bench
`default_nettype wire
